// ---- pkg/vtc_pkg.sv ----
// Purpose: constants, types and helpers of the legacy video access trap block
// Assumes: APB with 32-bit data; register index = byte address / 4
// Notes:   processor addresses are 20-bit physical addresses from the decode stage
package vtc_pkg;

   // ************************************************************
   // bus geometry
   // ************************************************************
   localparam int              ADDR_W          = 18;
   localparam int              IDX_W           = 16;
   localparam int              PHYS_W          = 20;
   localparam int              RANGE_CNT       = 3;

   // ************************************************************
   // register indexes (byte address is four times the index)
   // ************************************************************
   localparam logic [15:0]     IDX_TRAP_CTRL   = 16'h00B9;
   localparam logic [15:0]     IDX_REGION_MASK = 16'h00BA;
   localparam logic [15:0]     IDX_IRQ_STATUS  = 16'h00C0;
   localparam logic [15:0]     IDX_IRQ_MASK    = 16'h00C1;
   localparam logic [15:0]     IDX_WIN_BASE    = 16'h8100;
   localparam logic [15:0]     IDX_WIN_SIZE    = 16'h0200;
   localparam logic [15:0]     IDX_WRITE_PATH  = 16'h8140;
   localparam logic [15:0]     IDX_READ_PATH   = 16'h8144;
   localparam logic [15:0]     IDX_MEM_BASE    = 16'h8210;
   localparam logic [15:0]     IDX_LATCH       = 16'h8214;

   // ************************************************************
   // field positions
   // ************************************************************
   localparam int              CTRL_A0_BIT     = 0;
   localparam int              CTRL_B0_BIT     = 1;
   localparam int              CTRL_B8_BIT     = 2;
   localparam int              REGION_LSB      = 11;
   localparam int              REGION_MSB      = 15;

   // ************************************************************
   // legacy video ranges
   // ************************************************************
   localparam logic [19:0]     A0_LO           = 20'hA0000;
   localparam logic [19:0]     A0_HI           = 20'hAFFFF;
   localparam logic [19:0]     B0_LO           = 20'hB0000;
   localparam logic [19:0]     B0_HI           = 20'hB7FFF;
   localparam logic [19:0]     B8_LO           = 20'hB8000;
   localparam logic [19:0]     B8_HI           = 20'hBFFFF;

   // ************************************************************
   // values after reset
   // ************************************************************
   localparam logic [2:0]      RST_TRAP_CTRL   = 3'h0;
   localparam logic [31:0]     RST_WORD        = 32'h0000_0000;
   localparam logic [31:0]     RST_READ_PATH   = 32'h0000_0000;

   typedef struct packed {
      logic                    valid;
      logic [PHYS_W-1:0]       addr;
   } vtc_access_t;

   typedef struct packed {
      logic [31:0]             write_path;
      logic [31:0]             read_path;
      logic [31:0]             mem_base;
   } vtc_path_cfg_t;

   typedef struct packed {
      logic                    valid;
      logic [31:0]             data;
   } vtc_latch_load_t;

   function automatic logic in_range(input logic [19:0] a, input logic [19:0] lo, input logic [19:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   function automatic logic [31:0] merge_strb(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) r[i*8 +: 8] = wd[i*8 +: 8];
      end
      return r;
   endfunction

endpackage

// ---- rtl/vtc_sticky_irq.sv ----
// Purpose: sticky event status, mask and level interrupt
// Assumes: clear is write-one-to-clear from the register bus
// Notes:   an event in the clearing cycle keeps its bit set
`timescale 1ns/1ps
module vtc_sticky_irq #(
   parameter int W = 3
) (
   input  wire logic         ref_clk,  // clock
   input  wire logic         reset_n,  // async reset, active low
   input  wire logic [W-1:0] event_in, // one-cycle events
   input  wire logic [W-1:0] clear,    // bits to clear
   input  wire logic [W-1:0] mask,     // interrupt enables
   output logic      [W-1:0] status,   // sticky bits
   output logic              irq       // level interrupt
);
   logic [W-1:0] next_status;

   if (W < 1 || W > 32) begin : g_chk
      $error("vtc_sticky_irq: W must be 1 to 32");
   end

   always_comb begin
      next_status = (status & ~clear) | event_in;
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) status <= '0;
      else status <= next_status;
   end

   assign irq = |(status & mask);

endmodule // vtc_sticky_irq

// ---- rtl/vtc_top.sv ----
// Purpose: legacy video access trap configuration and pipeline register window
// Assumes: APB slave, no wait states; access port driven by same-clock decode logic
// Notes:   read data is prepared in the setup cycle and returned in the access cycle
`timescale 1ns/1ps
module vtc_top (
   input  wire logic                         ref_clk,     // 100 MHz clock
   input  wire logic                         reset_n,     // async reset, active low
   input  wire logic                         psel,        // APB select
   input  wire logic                         penable,     // APB enable
   input  wire logic                         pwrite,      // APB direction
   input  wire logic [vtc_pkg::ADDR_W-1:0]   paddr,       // APB byte address
   input  wire logic [31:0]                  pwdata,      // APB write data
   input  wire logic [3:0]                   pstrb,       // APB byte strobes
   output logic      [31:0]                  prdata,      // APB read data
   output logic                              pready,      // APB ready
   output logic                              pslverr,     // APB error
   input  wire vtc_pkg::vtc_access_t         acc,         // decode-stage access
   output logic                              trap_smi,    // trap request, same cycle
   output logic      [2:0]                   trap_range,  // range of the trap
   output logic                              irq,         // level interrupt
   output vtc_pkg::vtc_path_cfg_t            path_cfg,    // pipeline path controls
   input  wire vtc_pkg::vtc_latch_load_t     latch_load,  // latch update from pipeline
   output logic      [31:0]                  latch_value  // display latch
);

   // ************************************************************
   // register state
   // ************************************************************
   logic [2:0]                trap_ctrl;
   logic [31:0]               region_mask;
   logic [2:0]                irq_mask;
   logic [31:0]               write_path;
   logic [31:0]               read_path;
   logic [31:0]               mem_base;
   logic [31:0]               latch;
   logic [31:0]               rdata_q;
   logic                      err_q;
   logic [2:0]                next_trap_ctrl;
   logic [31:0]               next_region_mask;
   logic [2:0]                next_irq_mask;
   logic [31:0]               next_write_path;
   logic [31:0]               next_read_path;
   logic [31:0]               next_mem_base;
   logic [31:0]               next_latch;
   logic [31:0]               next_rdata_q;
   logic                      next_err_q;

   // ************************************************************
   // address decode
   // ************************************************************
   logic [vtc_pkg::IDX_W-1:0] idx;
   logic                      setup_ph;
   logic                      access_ph;
   logic                      in_window;
   logic                      mapped;
   logic                      wr_en;
   logic [31:0]               rd_mux;
   logic [2:0]                irq_status;
   logic [2:0]                irq_clear;

   assign idx       = paddr[vtc_pkg::ADDR_W-1:2];
   assign setup_ph  = psel && !penable;
   assign access_ph = psel && penable;
   // whole pipeline window answers, unused slots read zero
   assign in_window = (idx >= vtc_pkg::IDX_WIN_BASE)
                   && (idx <  vtc_pkg::IDX_WIN_BASE + vtc_pkg::IDX_WIN_SIZE);
   assign mapped    = (paddr[1:0] == 2'h0) && (in_window || idx == vtc_pkg::IDX_TRAP_CTRL
                   || idx == vtc_pkg::IDX_REGION_MASK || idx == vtc_pkg::IDX_IRQ_STATUS
                   || idx == vtc_pkg::IDX_IRQ_MASK);
   assign wr_en     = access_ph && pwrite && mapped;

   always_comb begin
      case (idx)
         vtc_pkg::IDX_TRAP_CTRL:   rd_mux = {29'h0, trap_ctrl};
         vtc_pkg::IDX_REGION_MASK: rd_mux = region_mask;
         vtc_pkg::IDX_IRQ_STATUS:  rd_mux = {29'h0, irq_status};
         vtc_pkg::IDX_IRQ_MASK:    rd_mux = {29'h0, irq_mask};
         vtc_pkg::IDX_WRITE_PATH:  rd_mux = write_path;
         vtc_pkg::IDX_READ_PATH:   rd_mux = read_path;
         vtc_pkg::IDX_MEM_BASE:    rd_mux = mem_base;
         vtc_pkg::IDX_LATCH:       rd_mux = latch;
         default:                  rd_mux = 32'h0000_0000;
      endcase
   end

   // ************************************************************
   // next-state of registers
   // ************************************************************
   always_comb begin
      next_trap_ctrl   = trap_ctrl;
      next_region_mask = region_mask;
      next_irq_mask    = irq_mask;
      next_write_path  = write_path;
      next_read_path   = read_path;
      next_mem_base    = mem_base;
      next_rdata_q     = rdata_q;
      next_err_q       = err_q;
      irq_clear        = 3'h0;
      // pipeline reload of the latch loses to a software write in the same cycle
      next_latch       = latch_load.valid ? latch_load.data : latch;
      if (setup_ph) begin
         next_err_q   = !mapped;
         next_rdata_q = (!pwrite && mapped) ? rd_mux : 32'h0000_0000;
      end
      if (wr_en) begin
         case (idx)
            vtc_pkg::IDX_TRAP_CTRL: begin
               if (pstrb[0]) next_trap_ctrl = pwdata[2:0];
            end
            vtc_pkg::IDX_REGION_MASK: begin
               next_region_mask = vtc_pkg::merge_strb(region_mask, pwdata, pstrb);
            end
            vtc_pkg::IDX_IRQ_STATUS: begin
               if (pstrb[0]) irq_clear = pwdata[2:0];
            end
            vtc_pkg::IDX_IRQ_MASK: begin
               if (pstrb[0]) next_irq_mask = pwdata[2:0];
            end
            vtc_pkg::IDX_WRITE_PATH: begin
               next_write_path = vtc_pkg::merge_strb(write_path, pwdata, pstrb);
            end
            vtc_pkg::IDX_READ_PATH: begin
               next_read_path = vtc_pkg::merge_strb(read_path, pwdata, pstrb);
            end
            vtc_pkg::IDX_MEM_BASE: begin
               next_mem_base = vtc_pkg::merge_strb(mem_base, pwdata, pstrb);
            end
            vtc_pkg::IDX_LATCH: begin
               next_latch = vtc_pkg::merge_strb(latch, pwdata, pstrb);
            end
            default: begin
            end
         endcase
      end
   end

   // undefined-at-reset registers are cleared anyway to keep X out of the pipeline
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         trap_ctrl   <= vtc_pkg::RST_TRAP_CTRL;
         region_mask <= vtc_pkg::RST_WORD;
         irq_mask    <= 3'h0;
         write_path  <= vtc_pkg::RST_WORD;
         read_path   <= vtc_pkg::RST_READ_PATH;
         mem_base    <= vtc_pkg::RST_WORD;
         latch       <= vtc_pkg::RST_WORD;
         rdata_q     <= vtc_pkg::RST_WORD;
         err_q       <= 1'b0;
      end else begin
         trap_ctrl   <= next_trap_ctrl;
         region_mask <= next_region_mask;
         irq_mask    <= next_irq_mask;
         write_path  <= next_write_path;
         read_path   <= next_read_path;
         mem_base    <= next_mem_base;
         latch       <= next_latch;
         rdata_q     <= next_rdata_q;
         err_q       <= next_err_q;
      end
   end

   // ************************************************************
   // bus answers and outputs
   // ************************************************************
   assign pready      = access_ph;
   assign pslverr     = access_ph && err_q;
   assign prdata      = rdata_q;
   assign latch_value = latch;
   always_comb begin
      path_cfg.write_path = write_path;
      path_cfg.read_path  = read_path;
      path_cfg.mem_base   = mem_base;
   end

   // ************************************************************
   // trap decision and interrupt
   // ************************************************************
   vtc_trap_decode u_decode (
      .range_en    (trap_ctrl),
      .region_mask (region_mask),
      .acc         (acc),
      .range_hit   (trap_range),
      .trap        (trap_smi)
   );

   vtc_sticky_irq #(
      .W (vtc_pkg::RANGE_CNT)
   ) u_irq (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .event_in (trap_range),
      .clear    (irq_clear),
      .mask     (irq_mask),
      .status   (irq_status),
      .irq      (irq)
   );

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   logic ctrl_written;
   logic read_written;
   logic [4:0] reg_n;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_written <= 1'b0;
         read_written <= 1'b0;
      end else begin
         if (wr_en && idx == vtc_pkg::IDX_TRAP_CTRL) ctrl_written <= 1'b1;
         if (wr_en && idx == vtc_pkg::IDX_READ_PATH) read_written <= 1'b1;
      end
   end
   assign reg_n = acc.addr[15:11];

   property p_b8_trap;
      acc.valid && acc.addr >= 20'hB8000 && acc.addr <= 20'hBFFFF
         |-> trap_smi == trap_ctrl[2] && trap_range == {trap_ctrl[2], 2'h0};
   endproperty
   a_b8_trap: assert property (p_b8_trap) else $error("B8 range trap wrong");

   property p_b0_trap;
      acc.valid && acc.addr >= 20'hB0000 && acc.addr <= 20'hB7FFF
         |-> trap_smi == trap_ctrl[1] && trap_range == {1'b0, trap_ctrl[1], 1'b0};
   endproperty
   a_b0_trap: assert property (p_b0_trap) else $error("B0 range trap wrong");

   property p_a0_trap;
      acc.valid && acc.addr >= 20'hA0000 && acc.addr <= 20'hAFFFF
         |-> trap_smi == (trap_ctrl[0] && region_mask[reg_n]);
   endproperty
   a_a0_trap: assert property (p_a0_trap) else $error("A0 range trap wrong");

   property p_ctrl_reset;
      !ctrl_written |-> trap_ctrl == 3'h0 && !trap_smi;
   endproperty
   a_ctrl_reset: assert property (p_ctrl_reset) else $error("control not zero before first write");

   // the gate that p_a0_trap reads must be the word software last wrote
   property p_mask_write;
      wr_en && idx == vtc_pkg::IDX_REGION_MASK && pstrb == 4'hF |=> region_mask == $past(pwdata);
   endproperty
   a_mask_write: assert property (p_mask_write) else $error("region gate not from written mask");

   property p_no_enable;
      trap_ctrl == 3'h0 |-> !trap_smi && trap_range == 3'h0;
   endproperty
   a_no_enable: assert property (p_no_enable) else $error("trap with no range enabled");

   property p_window_zero;
      setup_ph && !pwrite && paddr == 18'h20600 ##1 access_ph |-> prdata == 32'h0 && !pslverr;
   endproperty
   a_window_zero: assert property (p_window_zero) else $error("unused window slot answered wrong");

   property p_write_path;
      wr_en && idx == 16'h8140 && pstrb == 4'hF |=> path_cfg.write_path == $past(pwdata);
   endproperty
   a_write_path: assert property (p_write_path) else $error("write path not stored");

   property p_read_reset;
      !read_written |-> path_cfg.read_path == 32'h0;
   endproperty
   a_read_reset: assert property (p_read_reset) else $error("read path not zero from reset");

   property p_base_read;
      wr_en && idx == 16'h8210 && pstrb == 4'hF ##2 setup_ph && !pwrite && idx == 16'h8210
         |=> prdata == $past(path_cfg.mem_base, 1) && path_cfg.mem_base == $past(pwdata, 3);
   endproperty
   a_base_read: assert property (p_base_read) else $error("memory base readback wrong");

   property p_latch_sw;
      wr_en && idx == 16'h8214 && pstrb == 4'hF |=> latch_value == $past(pwdata);
   endproperty
   a_latch_sw: assert property (p_latch_sw) else $error("latch not overwritten");

   c_b8_trap: cover property (trap_range == 3'h4);
   c_a0_trap: cover property (trap_range == 3'h1 ##1 irq);
   c_slverr:  cover property (pslverr);
   c_latch:   cover property (latch_load.valid ##2 setup_ph && idx == 16'h8214);

endmodule // vtc_top

// ---- rtl/vtc_trap_decode.sv ----
// Purpose: range and region decision for one decode-stage access
// Assumes: address is already physical
// Notes:   purely combinational so the trap leaves in the access cycle
`timescale 1ns/1ps
module vtc_trap_decode (
   input  wire logic [2:0]           range_en, // per-range trap enables
   input  wire logic [31:0]          region_mask, // 2 KB region gates of low range
   input  wire vtc_pkg::vtc_access_t acc,      // access from decode stage
   output logic      [2:0]           range_hit, // enabled range that trapped
   output logic                      trap      // any trap
);
   logic [4:0] region;

   always_comb begin
      region = acc.addr[vtc_pkg::REGION_MSB:vtc_pkg::REGION_LSB];
      range_hit = 3'h0;
      // low range needs both enable and region gate
      range_hit[vtc_pkg::CTRL_A0_BIT] = acc.valid && range_en[vtc_pkg::CTRL_A0_BIT]
         && region_mask[region] && vtc_pkg::in_range(acc.addr, vtc_pkg::A0_LO, vtc_pkg::A0_HI);
      range_hit[vtc_pkg::CTRL_B0_BIT] = acc.valid && range_en[vtc_pkg::CTRL_B0_BIT]
         && vtc_pkg::in_range(acc.addr, vtc_pkg::B0_LO, vtc_pkg::B0_HI);
      range_hit[vtc_pkg::CTRL_B8_BIT] = acc.valid && range_en[vtc_pkg::CTRL_B8_BIT]
         && vtc_pkg::in_range(acc.addr, vtc_pkg::B8_LO, vtc_pkg::B8_HI);
      // mask only reaches the output through an enabled range
      trap = |range_hit;
   end

endmodule // vtc_trap_decode

// ---- testbench/tb.sv ----
// Purpose: self-checking bench of the legacy video access trap block
// Assumes: zero wait state APB slave, same-cycle trap outputs
// Notes:   expectations queue at the driver and are popped by the monitor
`timescale 1ns/1ps
module tb;
   logic                      ref_clk = 1'h0;
   logic                      reset_n = 1'h0;
   logic                      psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic [17:0]               paddr = 18'h00000;
   logic [31:0]               pwdata = 32'h0, prdata;
   logic                      pready, pslverr, trap_smi, irq, req = 1'h0;
   logic [2:0]                trap_range, e, sh_ctrl = 3'h0;
   logic [19:0]               req_addr = 20'h00000;
   logic [31:0]               latch_value, sh_mask, pv[4];
   vtc_pkg::vtc_access_t      acc;
   vtc_pkg::vtc_path_cfg_t    path_cfg;
   vtc_pkg::vtc_latch_load_t  latch_load = '0;
   logic [31:0]               rd_q[$];
   logic                      err_q[$];
   logic [2:0]                trap_q[$];
   int                        seed = 32'h6882, err_count = 0, num_checks = 0;
   logic [17:0] pa[4] = '{18'h20500, 18'h20510, 18'h20840, 18'h20850};
   logic [19:0] ea[8] = '{20'h9FFFF, 20'hA0000, 20'hAFFFF, 20'hB0000,
                          20'hB7FFF, 20'hB8000, 20'hBFFFF, 20'hC0000};
   always #5 ref_clk = ~ref_clk;
   vtc_top vtc_top_i (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .acc(acc), .trap_smi(trap_smi), .trap_range(trap_range),
      .irq(irq), .path_cfg(path_cfg), .latch_load(latch_load), .latch_value(latch_value));
   vtc_core_model vtc_core_model_i (.ref_clk(ref_clk), .reset_n(reset_n), .req(req),
      .req_addr(req_addr), .acc(acc));
   // ************************************************************
   // checking helpers
   // ************************************************************
   function automatic logic [2:0] exp_rng(input logic [19:0] a);
      exp_rng[0] = sh_ctrl[0] && a >= vtc_pkg::A0_LO && a <= vtc_pkg::A0_HI && sh_mask[a[15:11]];
      exp_rng[1] = sh_ctrl[1] && a >= vtc_pkg::B0_LO && a <= vtc_pkg::B0_HI;
      exp_rng[2] = sh_ctrl[2] && a >= vtc_pkg::B8_LO && a <= vtc_pkg::B8_HI;
   endfunction
   task chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      num_checks++;
      if (got !== ex) begin
         err_count++;
         $display("mismatch %s expected %h seen %h", nm, ex, got);
      end
   endtask
   task finish_test;
      $display("checks %0d mismatches %0d", num_checks, err_count);
      if (err_count == 0 && num_checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task apb(input logic w, input logic [17:0] a, input logic [31:0] d, input logic er);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      err_q.push_back(er);
      if (!w) rd_q.push_back(er ? 32'h0 : d);
      @(posedge ref_clk);
      penable <= 1'h1;
      @(posedge ref_clk);
      while (pready !== 1'h1 && n < 16) begin
         n++;
         @(posedge ref_clk);
      end
      if (n == 16) err_count++;
      psel <= 1'h0;
      penable <= 1'h0;
      // let the write land before any caller looks at outputs
      @(negedge ref_clk);
   endtask
   task access(input logic [19:0] a);
      @(posedge ref_clk);
      req <= 1'h1;
      req_addr <= a;
      trap_q.push_back(exp_rng(a));
   endtask
   always @(posedge ref_clk) begin
      if (psel === 1'h1 && penable === 1'h1 && pready === 1'h1) begin
         chk("pslverr", {31'h0, err_q.pop_front()}, {31'h0, pslverr});
         if (pwrite === 1'h0) chk("prdata", rd_q.pop_front(), prdata);
      end
      if (acc.valid === 1'h1) begin
         e = trap_q.pop_front();
         chk("trap_range", {29'h0, e}, {29'h0, trap_range});
         chk("trap_smi", {31'h0, |e}, {31'h0, trap_smi});
      end
   end
   initial begin
      #100000;
      err_count++;
      finish_test();
   end
   // ************************************************************
   // scenarios
   // ************************************************************
   initial begin
      int r, i;
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'h1;
      apb(1'h0, 18'h002E4, 32'h0, 1'h0);
      apb(1'h0, 18'h20510, 32'h0, 1'h0);
      chk("irq", 32'h0, {31'h0, irq});
      $display("test reset done");
      for (i = 0; i < 4; i++) begin
         pv[i] = $random(seed);
         apb(1'h1, pa[i], pv[i], 1'h0);
         apb(1'h0, pa[i], pv[i], 1'h0);
      end
      chk("write_path", pv[0], path_cfg.write_path);
      chk("read_path", pv[1], path_cfg.read_path);
      chk("mem_base", pv[2], path_cfg.mem_base);
      chk("latch", pv[3], latch_value);
      @(posedge ref_clk);
      latch_load <= '{valid: 1'h1, data: ~pv[3]};
      @(posedge ref_clk);
      latch_load <= '0;
      apb(1'h0, 18'h20850, ~pv[3], 1'h0);
      apb(1'h1, 18'h20600, pv[0], 1'h0);
      apb(1'h0, 18'h20600, 32'h0, 1'h0);
      apb(1'h0, 18'h20C00, 32'h0, 1'h1);
      apb(1'h0, 18'h00400, 32'h0, 1'h1);
      apb(1'h0, 18'h002E5, 32'h0, 1'h1);
      $display("test registers done");
      sh_mask = 32'hFFFFFFFF;
      apb(1'h1, 18'h002E8, sh_mask, 1'h0);
      for (r = 0; r < 4; r++) begin
         for (i = 0; i < 8; i++) access(ea[i]);
         @(posedge ref_clk);
         req <= 1'h0;
         sh_ctrl = (r == 3) ? 3'h7 : 3'h1 << r;
         apb(1'h1, 18'h002E4, {29'h0, sh_ctrl}, 1'h0);
         apb(1'h0, 18'h002E4, {29'h0, sh_ctrl}, 1'h0);
      end
      apb(1'h0, 18'h00300, 32'h7, 1'h0);
      chk("irq", 32'h0, {31'h0, irq});
      apb(1'h1, 18'h00304, 32'h2, 1'h0);
      chk("irq", 32'h1, {31'h0, irq});
      apb(1'h1, 18'h00300, 32'h2, 1'h0);
      apb(1'h0, 18'h00300, 32'h5, 1'h0);
      chk("irq", 32'h0, {31'h0, irq});
      $display("test ranges done");
      sh_ctrl = 3'h1;
      sh_mask = $random(seed);
      apb(1'h1, 18'h002E4, 32'h1, 1'h0);
      apb(1'h1, 18'h002E8, sh_mask, 1'h0);
      apb(1'h0, 18'h002E8, sh_mask, 1'h0);
      for (i = 0; i < 32; i++) begin
         pv[0] = $random(seed);
         access({4'hA, i[4:0], pv[0][10:0]});
      end
      access(20'hAF800);
      @(posedge ref_clk);
      req <= 1'h0;
      repeat (3) @(posedge ref_clk);
      $display("test regions done");
      finish_test();
   end
endmodule // tb

// ---- testbench/vtc_core_model.sv ----
// Purpose: decode-stage access source standing in for the processor core
// Assumes: the bench requests an access one cycle ahead of its use
// Notes:   idle cycles show the previous address inverted, so every second idle cycle shows the stale one
`timescale 1ns/1ps
module vtc_core_model (
   input  wire logic                       ref_clk,  // clock
   input  wire logic                       reset_n,  // async reset, active low
   input  wire logic                       req,      // present an access next cycle
   input  wire logic [vtc_pkg::PHYS_W-1:0] req_addr, // physical address
   output vtc_pkg::vtc_access_t            acc       // access to the trap logic
);
   vtc_pkg::vtc_access_t next_acc;
   // scrambled idle address exposes a trap decided on a stale address
   always_comb begin
      next_acc.valid = req;
      next_acc.addr  = req ? req_addr : ~acc.addr;
   end
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) acc <= '0;
      else acc <= next_acc;
   end
endmodule // vtc_core_model
